/* File: hdl/tbr_pkg.sv */
`default_nettype none

package tbr_pkg;

	// card states, gray along idle->ready->active->halt
	typedef enum logic [1:0] {
		TBR_IDLE   = 2'b00,
		TBR_READY  = 2'b01,
		TBR_ACTIVE = 2'b11,
		TBR_HALT   = 2'b10
	} tbr_state_t;

	// software control word
	typedef struct packed {
		logic       enable;
		logic [3:0] fwi;
		logic [7:0] afi;
	} tbr_ctrl_t;

	// command codes
	localparam logic [7:0] TBR_CMD_REQ    = 8'h05;
	localparam logic [7:0] TBR_CMD_ATTR   = 8'h1d;
	localparam logic [7:0] TBR_CMD_HALT   = 8'h50;
	localparam logic [7:0] TBR_RSP_CODE   = 8'h50;

	// request parameter byte: wake-up flag position
	localparam int         TBR_PAR_WUP_BIT = 3;

	// frame lengths in bytes, crc included
	localparam logic [3:0] TBR_LEN_REQ    = 4'd5;
	localparam logic [3:0] TBR_LEN_HALT   = 4'd7;
	localparam logic [3:0] TBR_LEN_ATTR   = 4'd11;
	localparam int         TBR_RXBUF      = 11;

	// answer layout
	localparam logic [3:0] TBR_TX_APP0    = 4'd5;
	localparam logic [3:0] TBR_TX_PI1     = 4'd9;
	localparam logic [3:0] TBR_TX_PI2     = 4'd10;
	localparam logic [3:0] TBR_TX_PI3     = 4'd11;
	localparam logic [3:0] TBR_TX_CRCLO   = 4'd12;
	localparam logic [3:0] TBR_TX_CRCHI   = 4'd13;
	localparam logic [7:0] TBR_APP_BYTE   = 8'h00;
	localparam logic [7:0] TBR_PI1        = 8'h91;
	localparam logic [3:0] TBR_PI2_FSIZE  = 4'b1000;
	localparam logic [3:0] TBR_PI2_PTYPE  = 4'b0001;
	localparam logic [1:0] TBR_PI3_ADC    = 2'b00;
	localparam logic [1:0] TBR_PI3_FO     = 2'b00;

	// crc_b
	localparam logic [15:0] TBR_CRC_INIT  = 16'hffff;
	localparam logic [15:0] TBR_CRC_POLY  = 16'h8408;
	localparam logic [15:0] TBR_CRC_GOOD  = 16'hf0b8;

	// register map (byte addresses)
	localparam logic [3:0] TBR_REG_CTRL   = 4'h0;
	localparam logic [3:0] TBR_REG_PUPI   = 4'h4;
	localparam logic [3:0] TBR_REG_STAT   = 4'h8;

	// control fields
	localparam int         TBR_CTRL_AFI_LSB = 0;
	localparam int         TBR_CTRL_FWI_LSB = 8;
	localparam int         TBR_CTRL_EN_BIT  = 16;
	localparam tbr_ctrl_t  TBR_CTRL_RST     = '{enable: 1'b1, fwi: 4'h4,
		afi: 8'h00};
	localparam logic [31:0] TBR_PUPI_RST    = 32'h0000_0000;

	// status fields
	localparam int         TBR_STAT_CNT_LSB = 8;

	// axi responses
	localparam logic [1:0] TBR_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TBR_RESP_SLVERR = 2'b10;

endpackage : tbr_pkg

`default_nettype wire

/* File: hdl/tbr_crc.sv */
`default_nettype none

module tbr_crc (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// byte feed
	input  wire logic        init,
	input  wire logic        en,
	input  wire logic [7:0]  din,
	// result
	output logic      [15:0] crc,
	output logic      [15:0] crc_upd
);
	import tbr_pkg::*;

	logic [15:0] crc_r;

	// one byte of reflected crc_b, lsb first
	always_comb begin
		logic [15:0] c;
		c = init ? TBR_CRC_INIT : crc_r;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ din[i]) begin
				c = (c >> 1) ^ TBR_CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crc_upd = c;
	end

	// running register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_r <= TBR_CRC_INIT;
		end else if (en) begin
			crc_r <= crc_upd;
		end else if (init) begin
			crc_r <= TBR_CRC_INIT;
		end
	end

	assign crc = crc_r;

endmodule : tbr_crc

`default_nettype wire

/* File: hdl/tbr_responder.sv */
// Implementation choices: the AXI4-Lite slave port and the address map.
`default_nettype none

module tbr_responder (
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// received bytes from the demodulator
	input  wire logic                rx_valid,
	input  wire logic [7:0]          rx_data,
	input  wire logic                rx_end,
	// answer bytes to the modulator
	output logic                     tx_valid,
	output logic      [7:0]          tx_data,
	output logic                     tx_last,
	input  wire logic                tx_ready,
	// card state
	output tbr_pkg::tbr_state_t      card_state,
	output logic                     cmd_enabled,
	// axi4-lite write address
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [3:0]          s_axi_awaddr,
	// axi4-lite write data
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	// axi4-lite write response
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic      [1:0]          s_axi_bresp,
	// axi4-lite read address
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [3:0]          s_axi_araddr,
	// axi4-lite read data
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic      [31:0]         s_axi_rdata,
	output logic      [1:0]          s_axi_rresp
);
	import tbr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	tbr_ctrl_t   ctrl_r;
	logic [31:0] pupi_r;
	logic [7:0]  answer_cnt_r;
	tbr_state_t  state_r;

	logic [7:0]  rx_buf_r [TBR_RXBUF];
	logic [3:0]  rx_cnt_r;
	logic        rx_bad_r;
	logic        rx_take;
	logic [15:0] rx_crc;

	logic        busy_r;
	logic [3:0]  tx_idx_r;
	logic        tx_acc;
	logic        tx_crc_en;
	logic [15:0] tx_crc;
	logic [15:0] tx_crc_upd;
	logic [7:0]  tx_next;
	logic [3:0]  tx_idx_nxt;

	logic        crc_ok;
	logic        afi_ok;
	logic        id_ok;
	logic        is_req;
	logic        is_wup;
	logic        do_answer;
	logic        do_halt;
	logic        do_attr;

	logic [3:0]  aw_addr_r;
	logic [3:0]  ar_addr_r;
	logic        aw_have_r;
	logic        w_have_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        wr_go;
	logic [31:0] ctrl_word;
	logic [31:0] ctrl_wr;
	logic [31:0] pupi_wr;

	////////////////////////////////////////////////////////////////////////
	// receive side

	// bytes are dropped while an answer is going out
	assign rx_take = rx_valid && !busy_r;

	tbr_crc u_rx_crc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.init    (rx_cnt_r == 4'd0),
		.en      (rx_take),
		.din     (rx_data),
		.crc     (rx_crc),
		.crc_upd ()
	);

	// byte store, count and frame damage flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt_r <= 4'd0;
			rx_bad_r <= 1'b0;
		end else if (rx_end) begin
			rx_cnt_r <= 4'd0;
			rx_bad_r <= 1'b0;
		end else if (rx_valid) begin
			if (busy_r || rx_cnt_r == 4'(TBR_RXBUF)) begin
				rx_bad_r <= 1'b1;
			end else begin
				rx_cnt_r <= rx_cnt_r + 4'd1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (rx_take && rx_cnt_r < 4'(TBR_RXBUF)) begin
			rx_buf_r[rx_cnt_r] <= rx_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame decode

	// residue over data and crc bytes
	assign crc_ok = (rx_crc == TBR_CRC_GOOD) && !rx_bad_r;

	// family selection: zero, full, or a single nibble with other zero
	always_comb begin
		logic [7:0] a;
		a = rx_buf_r[1];
		afi_ok = (a == 8'h00) || (a == ctrl_r.afi)
			|| (a[3:0] == 4'h0 && a[7:4] == ctrl_r.afi[7:4])
			|| (a[7:4] == 4'h0 && a[3:0] == ctrl_r.afi[3:0]);
	end

	assign id_ok = {rx_buf_r[1], rx_buf_r[2], rx_buf_r[3], rx_buf_r[4]}
		== pupi_r;

	// bits 7-5 and slot bits 2-0 never enter the decision
	assign is_req = rx_end && crc_ok && rx_cnt_r == TBR_LEN_REQ
		&& rx_buf_r[0] == TBR_CMD_REQ;
	assign is_wup = rx_buf_r[2][TBR_PAR_WUP_BIT];

	// idle answers both kinds, halt only wake-up
	assign do_answer = is_req && afi_ok && ctrl_r.enable
		&& (state_r == TBR_IDLE
		|| (state_r == TBR_HALT && is_wup));

	assign do_halt = rx_end && crc_ok && rx_cnt_r == TBR_LEN_HALT
		&& rx_buf_r[0] == TBR_CMD_HALT && id_ok
		&& (state_r == TBR_READY || state_r == TBR_ACTIVE);

	assign do_attr = rx_end && crc_ok && rx_cnt_r == TBR_LEN_ATTR
		&& rx_buf_r[0] == TBR_CMD_ATTR && id_ok
		&& state_r == TBR_READY;

	////////////////////////////////////////////////////////////////////////
	// card state

	// answered card becomes ready; halt and attribute move it on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= TBR_IDLE;
		end else if (do_answer) begin
			state_r <= TBR_READY;
		end else if (do_halt) begin
			state_r <= TBR_HALT;
		end else if (do_attr) begin
			state_r <= TBR_ACTIVE;
		end
	end

	// card state outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			card_state  <= TBR_IDLE;
			cmd_enabled <= 1'b0;
		end else begin
			card_state  <= state_r;
			cmd_enabled <= (state_r == TBR_ACTIVE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answer transmit

	assign tx_acc     = busy_r && tx_valid && tx_ready;
	assign tx_crc_en  = tx_acc && tx_idx_r < TBR_TX_CRCLO;
	assign tx_idx_nxt = tx_idx_r + 4'd1;

	tbr_crc u_tx_crc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.init    (do_answer),
		.en      (tx_crc_en),
		.din     (tx_data),
		.crc     (tx_crc),
		.crc_upd (tx_crc_upd)
	);

	// byte that follows the one being taken
	always_comb begin
		if (tx_idx_nxt < TBR_TX_APP0) begin
			tx_next = pupi_r[8'(31 - 8 * (tx_idx_nxt - 4'd1)) -: 8];
		end else if (tx_idx_nxt < TBR_TX_PI1) begin
			tx_next = TBR_APP_BYTE;
		end else if (tx_idx_nxt == TBR_TX_PI1) begin
			tx_next = TBR_PI1;
		end else if (tx_idx_nxt == TBR_TX_PI2) begin
			tx_next = {TBR_PI2_FSIZE, TBR_PI2_PTYPE};
		end else if (tx_idx_nxt == TBR_TX_PI3) begin
			tx_next = {ctrl_r.fwi, TBR_PI3_ADC, TBR_PI3_FO};
		end else if (tx_idx_nxt == TBR_TX_CRCLO) begin
			tx_next = ~tx_crc_upd[7:0];
		end else begin
			tx_next = ~tx_crc[15:8];
		end
	end

	// answer starts the edge after the request ends, no slot delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_r   <= 1'b0;
			tx_idx_r <= 4'd0;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
		end else if (do_answer) begin
			busy_r   <= 1'b1;
			tx_idx_r <= 4'd0;
			tx_valid <= 1'b1;
			tx_data  <= TBR_RSP_CODE;
			tx_last  <= 1'b0;
		end else if (tx_acc) begin
			if (tx_idx_r == TBR_TX_CRCHI) begin
				busy_r   <= 1'b0;
				tx_valid <= 1'b0;
				tx_last  <= 1'b0;
			end else begin
				tx_idx_r <= tx_idx_nxt;
				tx_data  <= tx_next;
				tx_last  <= (tx_idx_nxt == TBR_TX_CRCHI);
			end
		end
	end

	// answers sent, for software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			answer_cnt_r <= 8'h00;
		end else if (do_answer) begin
			answer_cnt_r <= answer_cnt_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write path

	// address and data taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_addr_r     <= 4'h0;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r     <= 1'b1;
				aw_addr_r     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r     <= 1'b1;
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
		end
	end

	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

	// enable at bit 16, waiting time at 11-8, family at 7-0
	assign ctrl_word = {15'h0000, ctrl_r.enable, 4'h0, ctrl_r.fwi,
		ctrl_r.afi};

	// byte-lane merge
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			ctrl_wr[8*b +: 8] = w_strb_r[b] ? w_data_r[8*b +: 8]
				: ctrl_word[8*b +: 8];
			pupi_wr[8*b +: 8] = w_strb_r[b] ? w_data_r[8*b +: 8]
				: pupi_r[8*b +: 8];
		end
	end

	// register update and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r       <= TBR_CTRL_RST;
			pupi_r       <= TBR_PUPI_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= TBR_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= TBR_RESP_OKAY;
			if (aw_addr_r == TBR_REG_CTRL) begin
				ctrl_r.afi    <= ctrl_wr[TBR_CTRL_AFI_LSB +: 8];
				ctrl_r.fwi    <= ctrl_wr[TBR_CTRL_FWI_LSB +: 4];
				ctrl_r.enable <= ctrl_wr[TBR_CTRL_EN_BIT];
			end else if (aw_addr_r == TBR_REG_PUPI) begin
				pupi_r <= pupi_wr;
			end else if (aw_addr_r != TBR_REG_STAT) begin
				s_axi_bresp <= TBR_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read path

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= TBR_RESP_OKAY;
			ar_addr_r     <= 4'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			ar_addr_r     <= s_axi_araddr;
			s_axi_rresp   <= TBR_RESP_OKAY;
			unique case (s_axi_araddr)
				TBR_REG_CTRL: s_axi_rdata <= ctrl_word;
				TBR_REG_PUPI: s_axi_rdata <= pupi_r;
				TBR_REG_STAT: s_axi_rdata <= {16'h0000, answer_cnt_r,
					5'h00, busy_r, state_r};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= TBR_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : tbr_responder

`default_nettype wire

/* File: bench/tbr_resp_monitor.sv */
`default_nettype none

module tbr_resp_mon (
	// clock and reset
	input wire logic                aclk,
	input wire logic                aresetn,
	// receive link
	input wire logic                rx_valid,
	input wire logic [7:0]          rx_data,
	input wire logic                rx_end,
	// transmit link
	input wire logic                tx_valid,
	input wire logic [7:0]          tx_data,
	input wire logic                tx_last,
	input wire logic                tx_ready,
	// card state
	input wire tbr_pkg::tbr_state_t card_state
);
	timeunit 1ns;
	timeprecision 100ps;
	import tbr_pkg::*;

	logic [3:0] idx_r;
	logic [1:0] rxn_r;
	logic [7:0] cmd_r;
	logic [7:0] par_r;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// index of the answer byte on offer
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idx_r <= 4'h0;
		else if (tx_valid && tx_ready)
			idx_r <= tx_last ? 4'h0 : idx_r + 4'h1;
	end

	// command and parameter byte of the frame
	always_ff @(posedge aclk) begin
		if (!aresetn || rx_end)
			rxn_r <= 2'h0;
		else if (rx_valid) begin
			rxn_r <= (rxn_r == 2'h3) ? rxn_r : rxn_r + 2'h1;
			if (rxn_r == 2'h0)
				cmd_r <= rx_data;
			if (rxn_r == 2'h2)
				par_r <= rx_data;
		end
	end

	////////////////////////////////
	property p_first;
		$rose(tx_valid) |-> tx_data == 8'h50;
	endproperty
	a_first: assert property (p_first) else $error("bad head");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("byte moved");
	property p_pi1;
		tx_valid && idx_r == 4'd9 |-> tx_data == 8'h91;
	endproperty
	a_pi1: assert property (p_pi1) else $error("bad rates");
	property p_pi2;
		tx_valid && idx_r == 4'd10 |-> tx_data == 8'h81;
	endproperty
	a_pi2: assert property (p_pi2) else $error("bad size");
	property p_pi3;
		tx_valid && idx_r == 4'd11 |-> tx_data[3:0] == 4'h0;
	endproperty
	a_pi3: assert property (p_pi3) else $error("bad coding");
	property p_last;
		tx_valid |-> tx_last == (idx_r == 4'd13);
	endproperty
	a_last: assert property (p_last) else $error("bad length");
	property p_cmd;
		rx_end && !tx_valid && cmd_r != 8'h05 |=> !tx_valid [*2];
	endproperty
	a_cmd: assert property (p_cmd) else $error("foreign answer");
	property p_halt;
		rx_end && !tx_valid && card_state == TBR_HALT && !par_r[3]
			|=> !tx_valid;
	endproperty
	a_halt: assert property (p_halt) else $error("halt answer");

endmodule : tbr_resp_mon

bind tbr_responder tbr_resp_mon mon_u (.aclk(aclk), .aresetn(aresetn),
	.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
	.tx_ready(tx_ready), .card_state(card_state));

`default_nettype wire

/* File: bench/tbr_reader.sv */
`default_nettype none

module tbr_rdr_model #(
	parameter int TR2_CYC = 5300 // 10 etu + 32/fs at 40 MHz
) (
	// clock
	input wire logic       aclk,
	// frame towards the card
	output var logic       rx_valid,
	output var logic [7:0] rx_data,
	output var logic       rx_end,
	// answer from the card
	input wire logic       tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_last,
	output var logic       tx_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	// link idle at start
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		tx_ready = 1'b0;
	end

	// crc_b step, reflected polynomial
	function automatic logic [15:0] crc_upd(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? (r >> 1) ^ 16'h8408 : r >> 1;
		return r;
	endfunction : crc_upd

	// send one frame, collect any answer
	task automatic xchg(input logic [7:0] f [14], input int n,
		input logic bad, input logic slow, output int got,
		output logic [7:0] a [14]);
		logic [15:0] c;
		int w;
		c = 16'hffff;
		got = 0;
		w = 0;
		for (int i = 0; i < n; i++)
			c = crc_upd(c, f[i]);
		c = ~c ^ {15'h0, bad};
		f[n] = c[7:0];
		f[n + 1] = c[15:8];
		for (int i = 0; i < n + 2; i++) begin
			@(posedge aclk);
			rx_valid <= 1'b1;
			rx_data <= f[i];
		end
		@(posedge aclk);
		rx_valid <= 1'b0;
		rx_data <= ~f[n + 1]; // released line toggles
		rx_end <= 1'b1;
		@(posedge aclk);
		rx_end <= 1'b0;
		tx_ready <= 1'b1;
		while (w < 6) begin
			@(posedge aclk);
			if (tx_valid && tx_ready && got < 14) begin
				a[got] = tx_data;
				got++;
				w = tx_last ? 6 : 0;
			end else if (!tx_valid)
				w++;
			tx_ready <= w < 6 && !(slow && tx_ready);
		end
		repeat (TR2_CYC) @(posedge aclk);
	endtask : xchg

endmodule : tbr_rdr_model

`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import tbr_pkg::*;

	logic aclk, aresetn, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
	logic cmd_enabled, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] rx_data, tx_data;
	logic [3:0] awaddr, araddr, wstrb, fwi;
	logic [31:0] wdata, rdata, pupi, rd;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] f [14], a [14], e [14];
	logic [15:0] c;
	tbr_state_t card_state;
	int n_fail = 0, checks_done = 0, cyc = 0, got;

	tbr_responder dut_u (.aclk(aclk), .aresetn(aresetn),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .card_state(card_state),
		.cmd_enabled(cmd_enabled), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

	// gap shortened, the card does not police it
	tbr_rdr_model #(.TR2_CYC(1000)) rdr_u (.aclk(aclk),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready));

	// 40 MHz clock and hang guard
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			print_verdict();
		end
	end

	////////////////////////////////
	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp);
		checks_done++;
		if (got_v !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge aclk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= ad;
		wdata <= d;
		wstrb <= 4'hf;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] ad);
		@(posedge aclk);
		{arvalid, rready} <= 2'h3;
		araddr <= ad;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		{rd, rs} = {rdata, rresp};
		rready <= 1'b0;
	endtask : axi_rd

	task automatic setup(input logic [31:0] ctl, input logic [31:0] id);
		axi_wr(TBR_REG_CTRL, ctl);
		axi_wr(TBR_REG_PUPI, id);
		chk({30'h0, rs}, 32'h0);
		pupi = id;
		fwi = ctl[11:8];
	endtask : setup

	// one frame; expect n_ans answer bytes
	task automatic frm(input logic [7:0] cmd, input logic [7:0] fam,
		input logic [7:0] par, input int n, input logic bad,
		input logic slow, input int n_ans);
		f[0] = cmd;
		for (int i = 0; i < 4; i++)
			f[i + 1] = pupi[31 - 8 * i -: 8];
		for (int i = 5; i < 9; i++)
			f[i] = 8'h00;
		if (n == 3)
			{f[1], f[2]} = {fam, par};
		rdr_u.xchg(f, n, bad, slow, got, a);
		chk(got, n_ans);
		if (n_ans == 14) begin
			e[0] = 8'h50;
			for (int i = 0; i < 4; i++)
				e[i + 1] = pupi[31 - 8 * i -: 8];
			for (int i = 5; i < 9; i++)
				e[i] = 8'h00;
			{e[9], e[10], e[11]} = {8'h91, 8'h81, fwi, 4'h0};
			c = 16'hffff;
			for (int i = 0; i < 12; i++)
				c = rdr_u.crc_upd(c, e[i]);
			{e[13], e[12]} = ~c;
			for (int i = 0; i < 14; i++)
				chk({24'h0, a[i]}, {24'h0, e[i]});
		end
	endtask : frm

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	////////////////////////////////
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wstrb, wdata} = '0;
		{pupi, fwi} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(TBR_REG_CTRL);
		chk(rd, 32'h0001_0400);
		axi_rd(TBR_REG_PUPI);
		chk(rd, 32'h0);
		axi_rd(4'hc);
		chk({30'h0, rs}, {30'h0, TBR_RESP_SLVERR});
		axi_wr(4'hc, 32'h0000_0000);
		chk({30'h0, rs}, {30'h0, TBR_RESP_SLVERR});
		setup(32'h0001_0737, 32'ha1b2_c3d4);
		$display("test registers done");
		frm(8'h05, 8'h30, 8'he7, 3, 1'b0, 1'b1, 14);
		chk({30'h0, card_state}, {30'h0, TBR_READY});
		frm(8'h05, 8'h37, 8'h00, 3, 1'b0, 1'b0, 0);
		frm(8'h50, 8'h00, 8'h00, 5, 1'b0, 1'b0, 0);
		chk({30'h0, card_state}, {30'h0, TBR_HALT});
		frm(8'h05, 8'h37, 8'h00, 3, 1'b0, 1'b0, 0);
		frm(8'h05, 8'h00, 8'h08, 3, 1'b0, 1'b0, 14);
		frm(8'h1d, 8'h00, 8'h00, 9, 1'b0, 1'b0, 0);
		chk({31'h0, cmd_enabled}, 32'h1);
		axi_rd(TBR_REG_STAT);
		chk(rd, 32'h0000_0203);
		$display("test states done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		setup(32'h0001_0337, 32'h5a0f_c381);
		frm(8'h06, 8'h30, 8'h00, 3, 1'b0, 1'b0, 0);
		frm(8'h05, 8'h12, 8'h00, 3, 1'b0, 1'b0, 0);
		frm(8'h05, 8'h30, 8'h00, 3, 1'b1, 1'b0, 0);
		frm(8'h05, 8'h07, 8'h08, 3, 1'b0, 1'b1, 14);
		for (int k = 0; k < 8; k++) begin
			frm(8'h50, 8'h00, 8'h00, 5, 1'b0, 1'b0, 0);
			frm(8'h05, 8'h00, {5'h01, 3'(k)}, 3, 1'b0, 1'b0, 14);
		end
		$display("test slots done");
		print_verdict();
	end

endmodule : tb_top

`default_nettype wire
